// [src/wscd_chan_mem.sv]
// stored channel memory, one write port, registered read
`timescale 1ns/100ps
`default_nettype none
module wscd_chan_mem
    import wscd_pkg::*;
#(
    parameter int DEPTH = CHAN_COUNT
) (
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_idx,
    input  wire wscd_chan_t wr_data,
    input  wire logic [7:0] rd_idx,
    output var  wscd_chan_t rd_data
);
    wscd_chan_t mem [DEPTH];

    always_ff @(posedge clk) begin
        if (ce && wr_en && (int'(wr_idx) < DEPTH)) begin
            mem[wr_idx] <= wr_data;
        end
    end

    // no reset on the array, so contents are unknown until written
    always_ff @(posedge clk) begin
        if (ce) begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule
`default_nettype wire

// [src/wscd_decoder.sv]
// weld setpoint decoder: control table registers, channel store and setpoint selection
//
// Notes on behaviour
// R1: robot writes control fields; the decoder only reads them, never alters them.
// R2: control table holds multi-bit setpoint fields and one-bit command fields.
// R3: unscaled feed codes 5..250, one count is 0.1 m/min.
// R4: unscaled feed codes above 50 round up to a multiple of five.
// R5: scaled feed maps 0..scale onto 0..250, never below 5.
// R6: robot feed used only with override set; otherwise stored channel feed.
// R7: unscaled voltage codes 80..460 in single-count steps of 0.1 V.
// R8: voltage applies only in MIG; other processes use synergic trim.
// R9: scaled voltage maps 0..scale onto 0..460, never below 80.
// R10: unscaled trim codes 0..180 mean -9.0..+9.0.
// R11: scaled trim uses voltage scale; zero is -9.0, scale is +9.0.
// R12: dynamics codes 0..18 mean -9..+9 on the synergic curve.
// R13: dynamics ignored while the root process is active.
// R14: voltage, trim, dynamics from robot only with override set.
// R15: channel select codes above 199 act as channel 199.
// R16: channel change reloads all stored settings, even during welding.
// R17: pulse peak codes 99..800, one count is one ampere.
// R18: out-of-range setpoint codes clamp to the nearest limit.
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
module wscd_decoder
    import wscd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output wscd_setpt_t      eff_setpoint
);
    // control table and configuration registers
    logic [31:0] ctrl;
    logic [15:0] feed_rate_setpoint;
    logic [15:0] arc_voltage;
    logic [15:0] synergic_trim;
    logic [7:0]  dynamics;
    logic [7:0]  stored_channel_select;
    logic [15:0] pulse_peak_amps;
    logic [15:0] feed_scale;
    logic [15:0] volt_scale;
    logic [31:0] ch_data_a;
    logic [31:0] ch_data_b;

    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        ch_wr;
    logic [7:0]  ch_wr_idx;

    wscd_ld_t    ld_state;
    logic [7:0]  rd_idx;
    logic [7:0]  loaded_ch;
    logic        reload;
    wscd_chan_t  mem_q;
    wscd_chan_t  chan;

    logic [15:0] feed_sc;
    logic [15:0] volt_sc;
    logic [15:0] trim_sc;
    logic [7:0]  sel_c;
    logic        robot_override_enable;
    logic        scaled_mode;

    logic [15:0] next_feed;
    logic [15:0] next_volt;
    logic [7:0]  next_trim;
    logic [7:0]  next_dyn;
    logic [15:0] next_pulse;
    logic [31:0] next_rdata;
    logic        next_rerr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // decode used by read and write paths; software may write only below the status words
    function automatic logic writable(input logic [7:0] a);
        writable = (a[1:0] == 2'b00) && (a <= REG_CH_WRITE);
    endfunction

    function automatic logic readable(input logic [7:0] a);
        readable = (a[1:0] == 2'b00) && (a <= REG_EFF_C);
    endfunction

    assign robot_override_enable = ctrl[CTRL_OVR_BIT];
    assign scaled_mode           = ctrl[CTRL_SCALED_BIT];
    assign do_write              = aw_held && w_held && !s_axi_bvalid;

    // write address and data are taken independently, in either order
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    // ready outputs registered; each drops the cycle after its channel is taken
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else if (ce) begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= writable(aw_addr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // robot-side fields are stored exactly as written and only read by the decoder
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl                  <= 32'h0000_0000;
            feed_rate_setpoint    <= 16'h0000;
            arc_voltage           <= 16'h0000;
            synergic_trim         <= 16'h0000;
            dynamics              <= 8'h00;
            stored_channel_select <= 8'h00;
            pulse_peak_amps       <= 16'h0000;
            feed_scale            <= SCALE_RST;
            volt_scale            <= SCALE_RST;
            ch_data_a             <= 32'h0000_0000;
            ch_data_b             <= 32'h0000_0000;
        end else if (ce && do_write) begin // R1 R2
            case (aw_addr)
                REG_CTRL:       ctrl <= merge(ctrl, w_data, w_strb);
                REG_FEED:       feed_rate_setpoint <= 16'(merge(32'(feed_rate_setpoint), w_data, w_strb));
                REG_VOLT:       arc_voltage <= 16'(merge(32'(arc_voltage), w_data, w_strb));
                REG_TRIM:       synergic_trim <= 16'(merge(32'(synergic_trim), w_data, w_strb));
                REG_DYN:        dynamics <= 8'(merge(32'(dynamics), w_data, w_strb));
                REG_CHSEL:      stored_channel_select <= 8'(merge(32'(stored_channel_select), w_data, w_strb));
                REG_PULSE:      pulse_peak_amps <= 16'(merge(32'(pulse_peak_amps), w_data, w_strb));
                REG_FEED_SCALE: feed_scale <= 16'(merge(32'(feed_scale), w_data, w_strb));
                REG_VOLT_SCALE: volt_scale <= 16'(merge(32'(volt_scale), w_data, w_strb));
                REG_CH_DATA_A:  ch_data_a <= merge(ch_data_a, w_data, w_strb);
                REG_CH_DATA_B:  ch_data_b <= merge(ch_data_b, w_data, w_strb);
                default:        ;
            endcase
        end
    end

    // a write to the commit word stores data words A and B into one channel
    always_comb begin
        ch_wr     = do_write && (aw_addr == REG_CH_WRITE) && w_strb[0];
        ch_wr_idx = w_data[7:0];
    end

    wscd_chan_mem u_mem (
        .clk     (clk),
        .ce      (ce),
        .wr_en   (ch_wr),
        .wr_idx  (ch_wr_idx),
        .wr_data (wscd_chan_t'({ch_data_b[9:0], ch_data_a})),
        .rd_idx  (rd_idx),
        .rd_data (mem_q)
    );

    assign sel_c = (stored_channel_select > CHAN_MAX) ? CHAN_MAX : stored_channel_select; // R15

    // channel loader; select is watched at all times, welding or not
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ld_state  <= LD_IDLE;
            rd_idx    <= 8'h00;
            loaded_ch <= 8'h00;
            chan      <= '0;
        end else if (ce) begin
            case (ld_state)
                LD_IDLE: begin
                    if (sel_c != loaded_ch || reload) begin // R16
                        rd_idx   <= sel_c;
                        ld_state <= LD_FETCH;
                    end
                end
                LD_FETCH: begin
                    ld_state <= LD_LOAD;
                end
                LD_LOAD: begin
                    chan      <= mem_q; // R16
                    loaded_ch <= rd_idx;
                    ld_state  <= LD_IDLE;
                end
                default: begin
                    ld_state <= LD_IDLE;
                end
            endcase
        end
    end

    // rewrite of the live channel forces a reload; the request wins over the clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reload <= 1'b1;
        end else if (ce) begin
            if (ch_wr && (ch_wr_idx == loaded_ch || ch_wr_idx == rd_idx)) begin
                reload <= 1'b1;
            end else if (ld_state == LD_IDLE) begin
                reload <= 1'b0;
            end
        end
    end

    wscd_scaler #(.FULL(FEED_FULL)) u_feed_sc (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .code   (feed_rate_setpoint),
        .scale  (feed_scale),
        .q      (feed_sc)
    );

    wscd_scaler #(.FULL(VOLT_FULL)) u_volt_sc (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .code   (arc_voltage),
        .scale  (volt_scale),
        .q      (volt_sc)
    );

    // trim shares the voltage scale
    wscd_scaler #(.FULL(TRIM_FULL)) u_trim_sc (
        .clk    (clk),
        .arst_n (arst_n),
        .ce     (ce),
        .code   (synergic_trim),
        .scale  (volt_scale), // R11
        .q      (trim_sc)
    );

    // setpoint selection; scaled results are one cycle older than raw fields
    always_comb begin
        next_feed = clamp16(feed_rate_setpoint, FEED_MIN, FEED_MAX); // R3 R18
        if (next_feed > FEED_FINE_TOP) begin
            next_feed = 16'(((next_feed + FEED_STEP - 16'h0001) / FEED_STEP) * FEED_STEP); // R4
        end
        if (scaled_mode) begin
            next_feed = (feed_sc < FEED_MIN) ? FEED_MIN : feed_sc; // R5
        end
        if (!robot_override_enable) begin
            next_feed = {8'h00, chan.feed}; // R6
        end

        next_volt = scaled_mode ? ((volt_sc < VOLT_MIN) ? VOLT_MIN : volt_sc) // R9
                                : clamp16(arc_voltage, VOLT_MIN, VOLT_MAX); // R7 R18
        next_trim = scaled_mode ? trim_sc[7:0]
                                : 8'(clamp16(synergic_trim, 16'h0000, TRIM_MAX)); // R10 R18
        next_dyn  = (dynamics > DYN_MAX) ? DYN_MAX : dynamics; // R12 R18
        if (!robot_override_enable) begin // R14
            next_volt = {7'h00, chan.volt};
            next_trim = chan.trim;
            next_dyn  = {3'h0, chan.dyn};
        end
        // voltage only steers MIG, trim every other process
        if (chan.proc == PROC_MIG) begin // R8
            next_trim = TRIM_MID;
        end else begin
            next_volt = 16'h0000;
        end
        if (chan.proc == PROC_ROOT) begin // R13
            next_dyn = DYN_MID;
        end

        next_pulse = {6'h00, chan.pulse};
        if (chan.proc == PROC_PULSE) begin
            next_pulse = clamp16(pulse_peak_amps, PULSE_MIN, PULSE_MAX); // R17 R18
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            eff_setpoint <= '0;
        end else if (ce) begin
            eff_setpoint.feed        <= next_feed;
            eff_setpoint.volt        <= next_volt;
            eff_setpoint.trim        <= next_trim;
            eff_setpoint.dyn         <= next_dyn;
            eff_setpoint.pulse       <= next_pulse;
            eff_setpoint.chan        <= loaded_ch;
            eff_setpoint.proc        <= chan.proc;
            eff_setpoint.volt_active <= (chan.proc == PROC_MIG); // R8
        end
    end

    // read path
    always_comb begin
        next_rerr = !readable(s_axi_araddr);
        case (s_axi_araddr)
            REG_CTRL:       next_rdata = ctrl;
            REG_FEED:       next_rdata = {16'h0000, feed_rate_setpoint};
            REG_VOLT:       next_rdata = {16'h0000, arc_voltage};
            REG_TRIM:       next_rdata = {16'h0000, synergic_trim};
            REG_DYN:        next_rdata = {24'h000000, dynamics};
            REG_CHSEL:      next_rdata = {24'h000000, stored_channel_select};
            REG_PULSE:      next_rdata = {16'h0000, pulse_peak_amps};
            REG_FEED_SCALE: next_rdata = {16'h0000, feed_scale};
            REG_VOLT_SCALE: next_rdata = {16'h0000, volt_scale};
            REG_CH_DATA_A:  next_rdata = ch_data_a;
            REG_CH_DATA_B:  next_rdata = ch_data_b;
            REG_EFF_A:      next_rdata = {eff_setpoint.volt, eff_setpoint.feed};
            REG_EFF_B:      next_rdata = {13'h0000, eff_setpoint.volt_active, eff_setpoint.proc,
                                          eff_setpoint.dyn, eff_setpoint.trim};
            REG_EFF_C:      next_rdata = {7'h00, ld_state != LD_IDLE, eff_setpoint.chan, eff_setpoint.pulse};
            default:        next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= next_rdata;
                s_axi_rresp  <= next_rerr ? RESP_SLVERR : RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [src/wscd_pkg.sv]
// shared constants, types and register map of the weld setpoint decoder
`default_nettype none
package wscd_pkg;

    // register byte offsets
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_FEED       = 8'h04;
    localparam logic [7:0] REG_VOLT       = 8'h08;
    localparam logic [7:0] REG_TRIM       = 8'h0C;
    localparam logic [7:0] REG_DYN        = 8'h10;
    localparam logic [7:0] REG_CHSEL      = 8'h14;
    localparam logic [7:0] REG_PULSE      = 8'h18;
    localparam logic [7:0] REG_FEED_SCALE = 8'h1C;
    localparam logic [7:0] REG_VOLT_SCALE = 8'h20;
    localparam logic [7:0] REG_CH_DATA_A  = 8'h24;
    localparam logic [7:0] REG_CH_DATA_B  = 8'h28;
    localparam logic [7:0] REG_CH_WRITE   = 8'h2C;
    localparam logic [7:0] REG_EFF_A      = 8'h30;
    localparam logic [7:0] REG_EFF_B      = 8'h34;
    localparam logic [7:0] REG_EFF_C      = 8'h38;

    // control register bits
    localparam int CTRL_OVR_BIT    = 0;
    localparam int CTRL_SCALED_BIT = 1;
    localparam int CTRL_PROC_LSB   = 2;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // code limits
    localparam logic [15:0] FEED_MIN       = 16'h0005;
    localparam logic [15:0] FEED_MAX       = 16'h00FA;
    localparam logic [15:0] FEED_FINE_TOP  = 16'h0032;
    localparam logic [15:0] FEED_STEP      = 16'h0005;
    localparam logic [15:0] VOLT_MIN       = 16'h0050;
    localparam logic [15:0] VOLT_MAX       = 16'h01CC;
    localparam logic [15:0] TRIM_MAX       = 16'h00B4;
    localparam logic [7:0]  TRIM_MID       = 8'h5A;
    localparam logic [7:0]  DYN_MAX        = 8'h12;
    localparam logic [7:0]  DYN_MID        = 8'h09;
    localparam logic [7:0]  CHAN_MAX       = 8'hC7;
    localparam int          CHAN_COUNT     = 200;
    localparam logic [15:0] PULSE_MIN      = 16'h0063;
    localparam logic [15:0] PULSE_MAX      = 16'h0320;
    localparam int          FEED_FULL      = 250;
    localparam int          VOLT_FULL      = 460;
    localparam int          TRIM_FULL      = 180;
    localparam logic [15:0] SCALE_RST      = 16'h0FFF;

    // welding process codes held in a stored channel
    localparam logic [1:0] PROC_MIG   = 2'h0;
    localparam logic [1:0] PROC_PULSE = 2'h1;
    localparam logic [1:0] PROC_ROOT  = 2'h2;
    localparam logic [1:0] PROC_OTHER = 2'h3;

    // one stored channel: low 32 bits are data word A, pulse sits in word B
    typedef struct packed {
        logic [9:0] pulse;
        logic [1:0] proc;
        logic [4:0] dyn;
        logic [7:0] trim;
        logic [8:0] volt;
        logic [7:0] feed;
    } wscd_chan_t;

    typedef struct packed {
        logic [15:0] feed;
        logic [15:0] volt;
        logic [7:0]  trim;
        logic [7:0]  dyn;
        logic [15:0] pulse;
        logic [7:0]  chan;
        logic [1:0]  proc;
        logic        volt_active;
    } wscd_setpt_t;

    typedef enum logic [2:0] {
        LD_IDLE  = 3'b001,
        LD_FETCH = 3'b010,
        LD_LOAD  = 3'b100
    } wscd_ld_t;

endpackage
`default_nettype wire

// [src/wscd_scaler.sv]
// scaled-mode mapping of a code onto 0..FULL counts, registered
`timescale 1ns/100ps
`default_nettype none
module wscd_scaler
    import wscd_pkg::*;
#(
    parameter int FULL = FEED_FULL
) (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        ce,
    input  wire logic [15:0] code,
    input  wire logic [15:0] scale,
    output logic      [15:0] q
);
    logic [15:0] code_c;
    logic [31:0] prod;

    always_comb begin
        code_c = (code > scale) ? scale : code;
        prod   = 32'(code_c) * 32'(FULL);
    end

    // truncating division; a zero scale maps every code to zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= 16'h0000;
        end else if (ce) begin
            q <= (scale == 16'h0000) ? 16'h0000 : 16'(prod / 32'(scale));
        end
    end
endmodule
`default_nettype wire

// [test/wscd_decoder_tb_top.sv]
// testbench: robot model writes the table, effective setpoints read back
`timescale 1ns/100ps
`default_nettype none
module wscd_decoder_tb_top
    import wscd_pkg::*;
;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        ce = 1'b1;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wscd_setpt_t eff_setpoint;
    int          err_total = 0;
    int          checks_done = 0;
    always #10 clk = ~clk;
    wscd_decoder dut (.*);
    wscd_robot robot (.*);
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        robot.xfer(1'b1, a, v, d, r);
    endtask
    // six cycles covers the slowest path, a channel reload
    task automatic tv(input logic [7:0] wa, input logic [31:0] wd, input logic [7:0] ra,
                      input int sh, input int w, input logic [31:0] e);
        wr(wa, wd);
        repeat (6) @(posedge clk);
        robot.xfer(1'b0, ra, 32'h0, d, r);
        chk((d >> sh) & ((32'h1 << w) - 1), e);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge clk);
        robot.xfer(1'b0, REG_FEED_SCALE, 32'h0, d, r);
        chk(d, {16'h0, SCALE_RST});
        robot.xfer(1'b0, 8'h3C, 32'h0, d, r);
        chk({d[29:0], r}, {30'h0, RESP_SLVERR});
        wr(REG_EFF_A, 32'h0);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        for (int c = 0; c < 3; c++) begin
            wr(REG_CH_DATA_A, {c[1:0], 5'h03, 8'h32, 9'h0C8, 8'h64});
            wr(REG_CH_DATA_B, 32'h12C);
            wr(REG_CH_WRITE, 32'd5 + c);
        end
        tv(REG_CHSEL, 5, REG_EFF_A, 0, 32, {16'd200, 16'd100});
        robot.xfer(1'b0, REG_EFF_B, 32'h0, d, r);
        chk(d, {13'h0, 1'b1, PROC_MIG, 8'h03, TRIM_MID});
        tv(REG_CHSEL, 250, REG_EFF_C, 16, 8, 199);
        tv(REG_CHSEL, 6, REG_EFF_B, 0, 32, {13'h0, 1'b0, PROC_PULSE, 8'h03, 8'h32});
        tv(REG_PULSE, 900, REG_EFF_C, 0, 16, 800);
        tv(REG_PULSE, 50, REG_EFF_C, 0, 16, 99);
        tv(REG_PULSE, 512, REG_EFF_A, 16, 16, 0);
        $display("stored channel test done");
        wr(REG_CTRL, 32'h1);
        tv(REG_TRIM, 200, REG_EFF_B, 0, 8, 180);
        tv(REG_TRIM, 45, REG_EFF_B, 0, 8, 45);
        tv(REG_DYN, 20, REG_EFF_B, 8, 8, 18);
        tv(REG_DYN, 0, REG_EFF_B, 8, 8, 0);
        tv(REG_CHSEL, 7, REG_EFF_B, 8, 8, 9);
        wr(REG_CHSEL, 32'h5);
        tv(REG_FEED, 3, REG_EFF_A, 0, 16, 5);
        tv(REG_FEED, 51, REG_EFF_A, 0, 16, 55);
        tv(REG_FEED, 50, REG_EFF_A, 0, 16, 50);
        tv(REG_FEED, 250, REG_EFF_A, 0, 16, 250);
        tv(REG_FEED, 300, REG_EFF_A, 0, 16, 250);
        tv(REG_VOLT, 70, REG_EFF_A, 16, 16, 80);
        tv(REG_VOLT, 460, REG_EFF_A, 16, 16, 460);
        tv(REG_VOLT, 500, REG_EFF_A, 16, 16, 460);
        tv(REG_VOLT, 123, REG_EFF_A, 16, 16, 123);
        tv(REG_CTRL, 0, REG_FEED, 0, 32, 300);
        tv(REG_CTRL, 0, REG_EFF_A, 0, 16, 100);
        $display("override test done");
        wr(REG_FEED_SCALE, 32'd1000);
        wr(REG_VOLT_SCALE, 32'd200);
        tv(REG_CTRL, 3, REG_EFF_A, 0, 16, 75);
        tv(REG_FEED, 0, REG_EFF_A, 0, 16, 5);
        tv(REG_FEED, 2000, REG_EFF_A, 0, 16, 250);
        tv(REG_VOLT, 100, REG_EFF_A, 16, 16, 230);
        tv(REG_VOLT, 0, REG_EFF_A, 16, 16, 80);
        wr(REG_CHSEL, 32'h6);
        tv(REG_TRIM, 100, REG_EFF_B, 0, 8, 90);
        tv(REG_TRIM, 200, REG_EFF_B, 0, 8, 180);
        $display("scaled test done");
        wrap_up();
    end
endmodule
`default_nettype wire

// [test/wscd_monitor.sv]
// port checker for the weld setpoint decoder
`timescale 1ns/100ps
`default_nettype none
module wscd_monitor
    import wscd_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire wscd_setpt_t eff_setpoint
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_volt_gated: assert property (!eff_setpoint.volt_active |-> eff_setpoint.volt == 16'h0000)
        else $error("voltage not zero outside mig");
    a_trim_mig: assert property (eff_setpoint.volt_active |-> eff_setpoint.trim == TRIM_MID)
        else $error("trim not neutral in mig");
    a_flag_proc: assert property (eff_setpoint.volt_active |-> eff_setpoint.proc == PROC_MIG)
        else $error("voltage active outside mig");
    a_root_dyn: assert property (eff_setpoint.proc == PROC_ROOT |-> eff_setpoint.dyn == DYN_MID)
        else $error("dynamics applied in root process");
    a_chan_limit: assert property (eff_setpoint.chan <= CHAN_MAX)
        else $error("channel beyond last");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_err_rdata: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    c_root: cover property (eff_setpoint.proc == PROC_ROOT);
    c_mig: cover property (eff_setpoint.volt_active);
    c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule
bind wscd_decoder wscd_monitor mon (.*);
`default_nettype wire

// [test/wscd_robot.sv]
// robot controller model: axi4-lite master filling the control table
`timescale 1ns/100ps
`default_nettype none
module wscd_robot (
    input  wire logic        clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready,
             s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    // one transfer at a time; robot writes whole 32-bit words only
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic [1:0] r);
        int n;
        @(posedge clk);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= wd;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        end else begin
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
        end
        for (n = 0; n < 64; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (w ? s_axi_bvalid : s_axi_rvalid) break;
        end
        rd = s_axi_rdata;
        r = w ? s_axi_bresp : s_axi_rresp;
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (n == 64) begin
            wscd_decoder_tb_top.err_total++;
            wscd_decoder_tb_top.wrap_up();
        end
    endtask
endmodule
`default_nettype wire
